// File: src/brg_guard.sv
// Block RAM with asynchronous local reset, global set/clear and FIFO clears.
// Assumes user logic sequences enables around resets; the memory does not check it.
`timescale 1ns/1ns
`default_nettype none
// Function
// - The global set/clear input acts asynchronously, independent of any clock edge.
// - The reset behaviour differs in FIFO use: global set/clear is forced on and only there do the FIFO clears act.
// - In FIFO use the global set/clear input is always enabled.
// - FIFO clear and read pointer clear act asynchronously, and only in FIFO use.
// - Synchronous reset with global set/clear disabled needs no enable sequencing.
module brg_guard (
  input wire logic sys_clk,
  input wire logic rst,
  input wire brg_pkg::brg_mode_t mode,
  input wire logic gsc_enable,
  input wire logic global_set_clear,
  input wire logic async_reset,
  input wire logic fifo_clear,
  input wire logic read_pointer_clear,
  input wire logic wr_clk_en,
  input wire logic rd_clk_en,
  input wire logic push_enable,
  input wire logic pop_enable,
  input wire logic [brg_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [brg_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [brg_pkg::DATA_W-1:0] wr_data,
  output logic [brg_pkg::DATA_W-1:0] rd_data,
  output logic fifo_empty,
  output logic fifo_full
);

  // ************************************************************
  // Reset combining
  // ************************************************************
  logic is_fifo;
  logic gsc_active;
  logic fifo_all_clear;
  logic fifo_rd_clear;
  logic wr_side_clear;
  logic rd_side_clear;

  assign is_fifo = (mode == brg_pkg::BRG_MODE_FIFO);
  // FIFO use ignores the disable so the global clear always reaches the pointers.
  assign gsc_active = global_set_clear & (gsc_enable | is_fifo);
  // The FIFO clears only count in FIFO use, so that a stray level on an unused
  // pin cannot wipe the read register while the array serves as RAM or ROM.
  assign fifo_all_clear = is_fifo & fifo_clear;
  assign fifo_rd_clear = is_fifo & read_pointer_clear;
  // One set of clears serves every mode, gated per mode as above; the enables feeding the array also differ.
  assign wr_side_clear = gsc_active | async_reset | fifo_all_clear;
  assign rd_side_clear = wr_side_clear | fifo_rd_clear;

  // ************************************************************
  // Pointer decoding
  // ************************************************************
  // Both pointers carry one wrap bit above the address, so equal pointers mean
  // empty and pointers that differ only in the wrap bit mean full.
  function automatic logic brg_ptr_empty(
    input logic [brg_pkg::PTR_W-1:0] wp,
    input logic [brg_pkg::PTR_W-1:0] rp
  );
    return (wp == rp);
  endfunction : brg_ptr_empty

  function automatic logic brg_ptr_full(
    input logic [brg_pkg::PTR_W-1:0] wp,
    input logic [brg_pkg::PTR_W-1:0] rp
  );
    return (wp[brg_pkg::PTR_W-1] != rp[brg_pkg::PTR_W-1]) &&
           (wp[brg_pkg::PTR_W-2:0] == rp[brg_pkg::PTR_W-2:0]);
  endfunction : brg_ptr_full

  // ************************************************************
  // Enables per mode
  // ************************************************************
  logic mem_wr;
  logic mem_rd;
  logic [brg_pkg::ADDR_W-1:0] mem_wr_addr;
  logic [brg_pkg::ADDR_W-1:0] mem_rd_addr;
  logic [brg_pkg::PTR_W-1:0] wr_ptr;
  logic [brg_pkg::PTR_W-1:0] rd_ptr;
  logic [brg_pkg::PTR_W-1:0] next_wr_ptr;
  logic [brg_pkg::PTR_W-1:0] next_rd_ptr;
  logic push_ok;
  logic pop_ok;
  logic ptr_empty;
  logic ptr_full;

  assign ptr_empty = brg_ptr_empty(wr_ptr, rd_ptr);
  assign ptr_full = brg_ptr_full(wr_ptr, rd_ptr);
  // Push and pop stand in the place of the clock enables in FIFO use.
  // A push into a full array or a pop from an empty one is dropped silently,
  // so the pointers can never pass each other.
  assign push_ok = is_fifo & push_enable & ~ptr_full;
  assign pop_ok = is_fifo & pop_enable & ~ptr_empty;

  always_comb begin
    mem_wr = 1'b0;
    mem_rd = 1'b0;
    mem_wr_addr = wr_addr;
    mem_rd_addr = rd_addr;
    unique case (mode)
      brg_pkg::BRG_MODE_RAM: begin
        mem_wr = wr_clk_en;
        mem_rd = rd_clk_en;
      end
      brg_pkg::BRG_MODE_ROM: begin
        mem_rd = rd_clk_en;
      end
      brg_pkg::BRG_MODE_FIFO: begin
        mem_wr = push_ok;
        mem_rd = pop_ok;
        mem_wr_addr = wr_ptr[brg_pkg::ADDR_W-1:0];
        mem_rd_addr = rd_ptr[brg_pkg::ADDR_W-1:0];
      end
      // The spare mode code leaves the array idle.
      default: begin
        mem_wr = 1'b0;
        mem_rd = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // FIFO pointers
  // ************************************************************
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (push_ok) begin
      next_wr_ptr = wr_ptr + 5'h01;
    end
    if (pop_ok) begin
      next_rd_ptr = rd_ptr + 5'h01;
    end
  end

  // The synchronous rst is the path needing no enable sequencing.
  // Limitation: the clears reach the asynchronous inputs of these flops directly;
  // nothing here guards against a release that races a clock edge, so the user
  // must keep the enables quiet around every clear.
  always_ff @(posedge sys_clk or posedge wr_side_clear) begin
    if (wr_side_clear) begin
      wr_ptr <= brg_pkg::RST_PTR;
    end else if (rst) begin
      wr_ptr <= brg_pkg::RST_PTR;
    end else begin
      wr_ptr <= next_wr_ptr;
    end
  end

  // Clearing only the read pointer rewinds reads without losing written words.
  always_ff @(posedge sys_clk or posedge rd_side_clear) begin
    if (rd_side_clear) begin
      rd_ptr <= brg_pkg::RST_PTR;
    end else if (rst) begin
      rd_ptr <= brg_pkg::RST_PTR;
    end else begin
      rd_ptr <= next_rd_ptr;
    end
  end

  // ************************************************************
  // Flags and array
  // ************************************************************
  logic next_empty;
  logic next_full;

  // The flags are decoded from the next pointers so that they change on the same
  // edge as the pointers, rather than one cycle behind them.
  always_comb begin
    next_empty = brg_ptr_empty(next_wr_ptr, next_rd_ptr);
    next_full = brg_ptr_full(next_wr_ptr, next_rd_ptr);
  end

  always_ff @(posedge sys_clk or posedge rd_side_clear) begin
    if (rd_side_clear) begin
      fifo_empty <= 1'b1;
      fifo_full <= 1'b0;
    end else if (rst) begin
      fifo_empty <= 1'b1;
      fifo_full <= 1'b0;
    end else begin
      fifo_empty <= next_empty;
      fifo_full <= next_full;
    end
  end

  // ************************************************************
  // Memory array
  // ************************************************************
  // The synchronous reset blocks both array ports, so a request in the reset
  // cycle cannot land; the read register keeps its last word instead.
  logic arr_wr;
  logic arr_rd;

  assign arr_wr = mem_wr & ~rst;
  assign arr_rd = mem_rd & ~rst;

  brg_mem u_mem (
    .sys_clk(sys_clk),
    .wr_en(arr_wr),
    .wr_addr(mem_wr_addr),
    .wr_data(wr_data),
    .rd_en(arr_rd),
    .rd_addr(mem_rd_addr),
    .rd_clear(rd_side_clear),
    .rd_data(rd_data)
  );

endmodule : brg_guard
`default_nettype wire

// File: src/brg_mem.sv
// Small memory array with a registered read port.
// Assumes one clock; writes and reads are qualified by the caller.
`timescale 1ns/1ns
`default_nettype none
module brg_mem (
  input wire logic sys_clk,
  input wire logic wr_en,
  input wire logic [brg_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [brg_pkg::DATA_W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [brg_pkg::ADDR_W-1:0] rd_addr,
  input wire logic rd_clear,
  output logic [brg_pkg::DATA_W-1:0] rd_data
);

  logic [brg_pkg::DATA_W-1:0] mem [brg_pkg::DEPTH];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // The clear is asynchronous so that the output latch follows the reset pins at once.
  always_ff @(posedge sys_clk or posedge rd_clear) begin
    if (rd_clear) begin
      rd_data <= brg_pkg::RST_DATA;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : brg_mem
`default_nettype wire

// File: src/brg_pkg.sv
// Package for the block RAM reset guard: modes, geometry and reset values.
// Assumes a single 20 MHz system clock domain.
package brg_pkg;

  // ************************************************************
  // Geometry
  // ************************************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int DEPTH = 16;
  localparam int PTR_W = 5;

  // ************************************************************
  // Use modes
  // ************************************************************
  typedef enum logic [1:0] {
    BRG_MODE_RAM = 2'h0,
    BRG_MODE_ROM = 2'h1,
    BRG_MODE_FIFO = 2'h2
  } brg_mode_t;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [DATA_W-1:0] RST_DATA = 8'h00;
  localparam logic [PTR_W-1:0] RST_PTR = 5'h00;

endpackage : brg_pkg

// File: testbench/brg_guard_monitor.sv
// Checker for the block RAM guard outputs while clears are active.
// Assumes it is bound to brg_guard and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module brg_guard_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire brg_pkg::brg_mode_t mode,
  input wire logic gsc_enable,
  input wire logic global_set_clear,
  input wire logic async_reset,
  input wire logic fifo_clear,
  input wire logic read_pointer_clear,
  input wire logic [brg_pkg::DATA_W-1:0] rd_data,
  input wire logic fifo_empty,
  input wire logic fifo_full
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  wire logic fm = mode == brg_pkg::BRG_MODE_FIFO;
  gsc_clear_a: assert property (global_set_clear && gsc_enable |-> rd_data == 8'h00 && fifo_empty && !fifo_full) else $error("global clear missed");
  any_mode_a: assert property (async_reset |-> rd_data == 8'h00 && fifo_empty && !fifo_full) else $error("local reset missed");
  fifo_gsc_a: assert property (fm && global_set_clear |-> rd_data == 8'h00 && fifo_empty) else $error("fifo global clear off");
  fifo_clr_a: assert property (fm && (fifo_clear || read_pointer_clear) |-> rd_data == 8'h00 && !fifo_full) else $error("fifo clear missed");
  gsc_off_a: assert property (global_set_clear && !gsc_enable && !fm && !async_reset |-> $stable(rd_data)) else $error("disabled clear acted");
  cover property (fifo_full);
  cover property (fm && read_pointer_clear);
  cover property (global_set_clear && !gsc_enable);
endmodule : brg_guard_monitor
bind brg_guard brg_guard_monitor brg_guard_monitor_i (.sys_clk, .rst, .mode, .gsc_enable,
  .global_set_clear, .async_reset, .fifo_clear, .read_pointer_clear, .rd_data, .fifo_empty,
  .fifo_full);
`default_nettype wire

// File: testbench/brg_guard_test.sv
// Self-checking bench for brg_guard driven through the user logic model.
// Assumes brg_user and the bound monitor are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; $display("Error %0t: got %h want %h", $time, a, b); end end
module brg_guard_test;
  logic sys_clk = 0, rst = 1, req = 0, rv = 0, rvd = 0, gsc_en = 1;
  brg_pkg::brg_mode_t mode = brg_pkg::BRG_MODE_RAM;
  logic [1:0] kind = 2'h0;
  logic [3:0] en = 4'h0, eo, clr, a = 4'h0;
  logic [7:0] d = 8'h00, s = 8'h3F, rd_data, m[16];
  logic fifo_empty, fifo_full;
  logic [9:0] x, q[$];
  int err_count = 0, compares = 0;
  brg_user brg_user_i (.sys_clk, .rst, .req, .kind, .en_in(en), .en_out(eo), .clr);
  brg_guard brg_guard_i (.sys_clk, .rst, .mode, .gsc_enable(gsc_en), .global_set_clear(clr[1]),
    .async_reset(clr[0]), .fifo_clear(clr[2]), .read_pointer_clear(clr[3]), .wr_clk_en(eo[0]),
    .rd_clk_en(eo[1]), .push_enable(eo[2]), .pop_enable(eo[3]), .wr_addr(a), .rd_addr(a),
    .wr_data(d), .rd_data, .fifo_empty, .fifo_full);
  initial forever #25 sys_clk = ~sys_clk;
  function automatic logic [7:0] lf(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lf
  task op(input logic [3:0] e, input logic [3:0] ad, input logic c, input logic [9:0] w);
    @(posedge sys_clk);
    en <= e; a <= ad; d <= s; rv <= c;
    if (c) q.push_back(w);
    s = lf(s);
  endtask : op
  task sq(input logic [1:0] k, input logic c, input logic [9:0] w);
    op(4'h0, 4'h0, 1'b0, 10'h000);
    req <= 1'b1; kind <= k;
    @(posedge sys_clk) req <= 1'b0;
    repeat (3) @(posedge sys_clk);
    op(4'h0, 4'h0, c, w);
  endtask : sq
  task end_of_test();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  // ******************
  // Result watcher
  // ******************
  always @(posedge sys_clk) rvd <= rv;
  always @(negedge sys_clk) if (rvd) begin x = q.pop_front(); `CHK({rd_data, fifo_empty, fifo_full}, x) end
  initial begin #100000; err_count++; end_of_test(); end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    sq(2'h0, 1'b1, 10'h002);
    for (int i = 0; i < 4; i++) begin m[i] = s; op(4'h1, i[3:0], 1'b0, 10'h000); end
    for (int i = 0; i < 4; i++) op(4'h2, i[3:0], 1'b1, {m[i], 2'b10});
    mode <= brg_pkg::BRG_MODE_ROM;
    op(4'h1, 4'h0, 1'b0, 10'h000);
    op(4'h2, 4'h0, 1'b1, {m[0], 2'b10});
    gsc_en <= 1'b0;
    sq(2'h1, 1'b1, {m[0], 2'b10});
    gsc_en <= 1'b1;
    sq(2'h1, 1'b1, 10'h002);
    mode <= brg_pkg::BRG_MODE_FIFO; gsc_en <= 1'b0;
    for (int i = 0; i < 17; i++) begin if (i < 16) m[i] = s; op(4'h4, 4'h0, i == 16, 10'h001); end
    for (int i = 0; i < 17; i++) op(4'h8, 4'h0, 1'b1, {m[(i > 15) ? 15 : i], i > 14, 1'b0});
    op(4'h4, 4'h0, 1'b0, 10'h000);
    sq(2'h1, 1'b1, 10'h002);
    op(4'h4, 4'h0, 1'b0, 10'h000);
    sq(2'h3, 1'b0, 10'h000);
    sq(2'h2, 1'b1, 10'h002);
    op(4'h0, 4'h0, 1'b0, 10'h000);
    repeat (3) @(posedge sys_clk);
    end_of_test();
  end
endmodule : brg_guard_test
`default_nettype wire

// File: testbench/brg_user.sv
// User logic model that gates enables around one clear pulse.
// Assumes req is held one cycle; kind picks the clear line.
`timescale 1ns/1ns
`default_nettype none
module brg_user (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic req,
  input wire logic [1:0] kind,
  input wire logic [3:0] en_in,
  output logic [3:0] en_out,
  output logic [3:0] clr
);
  logic [1:0] st;
  always_ff @(posedge sys_clk) begin
    if (rst || (st == 2'h0 && !req)) st <= 2'h0;
    else st <= st + 2'h1;
  end
  // Quiet enables beat the clock-steady option, so no frequency limit is needed.
  assign en_out = (st == 2'h0 && !req) ? en_in : 4'h0;
  assign clr = (st == 2'h2) ? 4'h1 << kind : 4'h0;
endmodule : brg_user
`default_nettype wire
